// ---- design/rscfe_pkg.sv ----
// package for the remote serial command front end
package rscfe_pkg;

  // character codes
  localparam logic [7:0] CHR_EOS     = 8'h0A;
  localparam logic [7:0] CHR_TOGGLE  = 8'h01;
  localparam logic [7:0] CHR_OPEN1   = 8'h03;
  localparam logic [7:0] CHR_OPEN2   = 8'h02;
  localparam logic [7:0] CHR_CTRL_HI = 8'h1F;
  localparam logic [7:0] CHR_DEF_ADR = 8'h41;

  // register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_ADDR   = 8'h04;
  localparam logic [7:0] A_SRQ    = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_IRQ    = 8'h10;
  localparam logic [7:0] A_MASK   = 8'h14;
  localparam logic [7:0] A_RXDATA = 8'h18;
  localparam logic [7:0] A_TXDATA = 8'h1C;

  // control register fields
  localparam int CTRL_REMOTE_EN = 0;
  localparam int CTRL_SRQ_EN    = 1;
  localparam int CTRL_ADDR_SET  = 2;

  // interrupt bit positions
  localparam int IRQ_W       = 5;
  localparam int IRQ_CMD     = 0;
  localparam int IRQ_OPEN    = 1;
  localparam int IRQ_TOGGLE  = 2;
  localparam int IRQ_CHAIN   = 3;
  localparam int IRQ_TXLOST  = 4;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // open sequence parser
  typedef enum logic [1:0] {
    OPS_IDLE = 2'b00,
    OPS_GOT3 = 2'b01,
    OPS_GOT2 = 2'b10
  } rscfe_open_e;

  // serial byte stream item
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rscfe_byte_s;

  // axi lite write side to slave
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
  } rscfe_axw_s;

  // axi lite read side to slave
  typedef struct packed {
    logic       arvalid;
    logic [7:0] araddr;
    logic       rready;
  } rscfe_axr_s;

  // axi lite answers from slave
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rscfe_axo_s;

  // all state of the front end
  typedef struct packed {
    rscfe_axo_s  ax;
    logic        aw_got;
    logic [7:0]  aw_adr;
    logic        w_got;
    logic [31:0] w_dat;
    logic [3:0]  w_stb;
    logic        remote_en;
    logic        srq_en;
    logic        addr_set;
    logic [7:0]  unit_adr;
    logic [7:0]  srq_chr;
    logic        remote;
    logic        unit_open;
    rscfe_open_e ops;
    logic [7:0]  rx_last;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic        irq;
    rscfe_byte_s tx;
    rscfe_byte_s fwd;
    logic        chain_rst;
    logic        cmd_done;
    logic        boot;
  } rscfe_state_s;

endpackage

// ---- design/rscfe_top.sv ----
// remote serial command front end: framing, mode, addressing, srq
`timescale 1ns/1ps
// Function
// - commands are ascii ended by line feed 0x0A, which ends the command
// - returned data goes out as ascii followed by line feed
// - no hardware handshake; link pacing uses no flow-control lines
// - with service request mode on, send one character per event; code sends it only in remote mode, none in a cycle echoing a control byte
// - service request character comes from a programmable register
// - remote operation needs remote enable equal 1 plus unit address; code enters remote on toggle byte 0x01 even with enable 0
// - unconfigured unit address defaults to ascii A
// - unit address setting holds the numeric ascii code
// - after reset remote while enable is 1, local once it is 0; code takes enable once at reset release, when it is 0
// - remote not enabled: come out of reset in local mode
// - open sequence 0x03, 0x02, address opens the matching unit
// - byte 0x01 toggles between local and remote mode
// - each open sequence closes the open unit and opens the new one
// - malformed open sequence propagates a reset along the chain; code sends none when toggle byte 0x01 breaks the sequence
// - toggle byte acts on every chained unit
// - bytes 0x00..0x1F are global and echoed back to the host
module rscfe_top
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // axi4-lite slave
  input  wire rscfe_pkg::rscfe_axw_s axw_i,
  input  wire rscfe_pkg::rscfe_axr_s axr_i,
  output      rscfe_pkg::rscfe_axo_s axo_o,
  // serial bytes from the uart receiver
  input  wire rscfe_pkg::rscfe_byte_s rx_i,
  // bytes toward the host and down the chain
  output      rscfe_pkg::rscfe_byte_s tx_o,
  output      rscfe_pkg::rscfe_byte_s fwd_o,
  // command and status
  input  wire logic                  event_i,
  output      logic                  remote_o,
  output      logic                  unit_open_o,
  output      logic                  chain_rst_o,
  output      logic                  cmd_done_o,
  output      logic                  irq_o
);

  rscfe_pkg::rscfe_state_s st_ff;
  rscfe_pkg::rscfe_state_s nxt_st;

  // local copy of the interrupt width, declared before any use
  localparam int IRQ_W_T = rscfe_pkg::IRQ_W;

  // control characters are the range 0x00..0x1F
  function automatic logic is_ctrl(input logic [7:0] c);
    is_ctrl = (c <= rscfe_pkg::CHR_CTRL_HI);
  endfunction

  // effective unit address, A when none configured
  function automatic logic [7:0] eff_adr(input logic       set,
                                         input logic [7:0] a);
    eff_adr = set ? a : rscfe_pkg::CHR_DEF_ADR;
  endfunction

  // next state
  always_comb
  begin
    logic [IRQ_W_T-1:0] ev;
    logic               wr_go;
    logic               tx_busy;
    ev      = '0;
    nxt_st  = st_ff;
    wr_go   = 1'b0;
    tx_busy = 1'b0;
    nxt_st.tx.valid  = 1'b0;
    nxt_st.fwd.valid = 1'b0;
    nxt_st.chain_rst = 1'b0;
    nxt_st.cmd_done  = 1'b0;
    nxt_st.boot      = 1'b0;
    // mode taken once after reset from stored enable
    if (st_ff.boot)
      nxt_st.remote = st_ff.remote_en;
    // serial byte handling, no handshake: one byte per valid
    if (rx_i.valid)
    begin
      nxt_st.rx_last = rx_i.data;
      if (is_ctrl(rx_i.data))
      begin
        nxt_st.tx  = rx_i;
        nxt_st.fwd = rx_i;
        tx_busy    = 1'b1;
      end
      if (rx_i.data == rscfe_pkg::CHR_TOGGLE)
      begin
        nxt_st.remote = !st_ff.remote;
        nxt_st.ops    = rscfe_pkg::OPS_IDLE;
        ev[rscfe_pkg::IRQ_TOGGLE] = 1'b1;
      end
      else
      begin
        case (st_ff.ops)
          rscfe_pkg::OPS_IDLE:
          begin
            if (rx_i.data == rscfe_pkg::CHR_OPEN1)
              nxt_st.ops = rscfe_pkg::OPS_GOT3;
          end
          rscfe_pkg::OPS_GOT3:
          begin
            if (rx_i.data == rscfe_pkg::CHR_OPEN2)
              nxt_st.ops = rscfe_pkg::OPS_GOT2;
            else
            begin
              nxt_st.ops       = rscfe_pkg::OPS_IDLE;
              nxt_st.chain_rst = 1'b1;
              nxt_st.unit_open = 1'b0;
              ev[rscfe_pkg::IRQ_CHAIN] = 1'b1;
            end
          end
          rscfe_pkg::OPS_GOT2:
          begin
            nxt_st.ops = rscfe_pkg::OPS_IDLE;
            if (is_ctrl(rx_i.data))
            begin
              nxt_st.chain_rst = 1'b1;
              nxt_st.unit_open = 1'b0;
              ev[rscfe_pkg::IRQ_CHAIN] = 1'b1;
            end
            else
            begin
              // close whatever was open, open on match
              nxt_st.unit_open = st_ff.remote && rx_i.data ==
                eff_adr(st_ff.addr_set, st_ff.unit_adr);
              ev[rscfe_pkg::IRQ_OPEN] = 1'b1;
              nxt_st.fwd = rx_i;
            end
          end
          default:
            nxt_st.ops = rscfe_pkg::OPS_IDLE;
        endcase
        // printable byte: a closed unit passes it on even mid-sequence
        if (!is_ctrl(rx_i.data))
        begin
          if (!(st_ff.unit_open && st_ff.remote))
            nxt_st.fwd = rx_i;
        end
        // line feed closes a command for the open unit
        if (rx_i.data == rscfe_pkg::CHR_EOS &&
            st_ff.unit_open && st_ff.remote)
        begin
          nxt_st.cmd_done = 1'b1;
          ev[rscfe_pkg::IRQ_CMD] = 1'b1;
        end
      end
    end
    // service request character on an event
    if (event_i && st_ff.srq_en && st_ff.remote)
    begin
      if (tx_busy)
        ev[rscfe_pkg::IRQ_TXLOST] = 1'b1;
      else
      begin
        nxt_st.tx.valid = 1'b1;
        nxt_st.tx.data  = st_ff.srq_chr;
        tx_busy         = 1'b1;
      end
    end
    // axi write: address and data in either order
    nxt_st.ax.bvalid  = st_ff.ax.bvalid && !axw_i.bready;
    nxt_st.ax.awready = 1'b0;
    nxt_st.ax.wready  = 1'b0;
    if (axw_i.awvalid && !st_ff.aw_got && !st_ff.ax.bvalid)
    begin
      nxt_st.aw_got     = 1'b1;
      nxt_st.aw_adr     = axw_i.awaddr;
      nxt_st.ax.awready = 1'b1;
    end
    if (axw_i.wvalid && !st_ff.w_got && !st_ff.ax.bvalid)
    begin
      nxt_st.w_got     = 1'b1;
      nxt_st.w_dat     = axw_i.wdata;
      nxt_st.w_stb     = axw_i.wstrb;
      nxt_st.ax.wready = 1'b1;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.ax.bvalid)
    begin
      wr_go            = 1'b1;
      nxt_st.aw_got    = 1'b0;
      nxt_st.w_got     = 1'b0;
      nxt_st.ax.bvalid = 1'b1;
      nxt_st.ax.bresp  = rscfe_pkg::RESP_OKAY;
    end
    if (wr_go)
    begin
      case (st_ff.aw_adr)
        rscfe_pkg::A_CTRL:
          if (st_ff.w_stb[0])
          begin
            nxt_st.remote_en = st_ff.w_dat[rscfe_pkg::CTRL_REMOTE_EN];
            nxt_st.srq_en    = st_ff.w_dat[rscfe_pkg::CTRL_SRQ_EN];
            nxt_st.addr_set  = st_ff.w_dat[rscfe_pkg::CTRL_ADDR_SET];
          end
        rscfe_pkg::A_ADDR:
          if (st_ff.w_stb[0])
            nxt_st.unit_adr = st_ff.w_dat[7:0];
        rscfe_pkg::A_SRQ:
          if (st_ff.w_stb[0])
            nxt_st.srq_chr = st_ff.w_dat[7:0];
        rscfe_pkg::A_MASK:
          if (st_ff.w_stb[0])
            nxt_st.irq_mask = st_ff.w_dat[IRQ_W_T-1:0];
        rscfe_pkg::A_TXDATA:
          if (st_ff.w_stb[0] && !tx_busy)
          begin
            nxt_st.tx.valid = 1'b1;
            nxt_st.tx.data  = st_ff.w_dat[7:0];
          end
          else if (st_ff.w_stb[0])
            ev[rscfe_pkg::IRQ_TXLOST] = 1'b1;
        default:
          nxt_st.ax.bresp = rscfe_pkg::RESP_SLVERR;
      endcase
    end
    // axi read, answered one cycle after the address
    nxt_st.ax.arready = 1'b0;
    nxt_st.ax.rvalid  = st_ff.ax.rvalid && !axr_i.rready;
    nxt_st.irq_st     = st_ff.irq_st;
    if (axr_i.arvalid && !st_ff.ax.rvalid && !st_ff.ax.arready)
    begin
      nxt_st.ax.arready = 1'b1;
      nxt_st.ax.rvalid  = 1'b1;
      nxt_st.ax.rresp   = rscfe_pkg::RESP_OKAY;
      nxt_st.ax.rdata   = '0;
      case (axr_i.araddr)
        rscfe_pkg::A_CTRL:
        begin
          nxt_st.ax.rdata[rscfe_pkg::CTRL_REMOTE_EN] = st_ff.remote_en;
          nxt_st.ax.rdata[rscfe_pkg::CTRL_SRQ_EN]    = st_ff.srq_en;
          nxt_st.ax.rdata[rscfe_pkg::CTRL_ADDR_SET]  = st_ff.addr_set;
        end
        rscfe_pkg::A_ADDR:
          nxt_st.ax.rdata[7:0] = eff_adr(st_ff.addr_set, st_ff.unit_adr);
        rscfe_pkg::A_SRQ:
          nxt_st.ax.rdata[7:0] = st_ff.srq_chr;
        rscfe_pkg::A_STATUS:
        begin
          nxt_st.ax.rdata[0] = st_ff.remote;
          nxt_st.ax.rdata[1] = st_ff.unit_open;
          nxt_st.ax.rdata[3:2] = st_ff.ops;
        end
        rscfe_pkg::A_IRQ:
        begin
          nxt_st.ax.rdata[IRQ_W_T-1:0] = st_ff.irq_st;
          nxt_st.irq_st = '0;                    // read clears
        end
        rscfe_pkg::A_MASK:
          nxt_st.ax.rdata[IRQ_W_T-1:0] = st_ff.irq_mask;
        rscfe_pkg::A_RXDATA:
          nxt_st.ax.rdata[7:0] = st_ff.rx_last;
        rscfe_pkg::A_TXDATA:
          nxt_st.ax.rdata[7:0] = st_ff.tx.data;
        default:
          nxt_st.ax.rresp = rscfe_pkg::RESP_SLVERR;
      endcase
    end
    // new events win over the read clear
    nxt_st.irq_st = nxt_st.irq_st | ev;
    nxt_st.irq    = |(nxt_st.irq_st & nxt_st.irq_mask);
  end

  // state register; boot flag triggers mode pickup after release
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_ff      <= '0;
      st_ff.boot <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from flops
  assign axo_o       = st_ff.ax;
  assign tx_o        = st_ff.tx;
  assign fwd_o       = st_ff.fwd;
  assign remote_o    = st_ff.remote;
  assign unit_open_o = st_ff.unit_open;
  assign chain_rst_o = st_ff.chain_rst;
  assign cmd_done_o  = st_ff.cmd_done;
  assign irq_o       = st_ff.irq;

endmodule

// ---- sim/rscfe_top_props.sv ----
// assertion checker for the serial command front end
`timescale 1ns/1ps
module rscfe_top_props
(
  // clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_b_i,
  // register bus
  input wire rscfe_pkg::rscfe_axw_s  axw_i,
  input wire rscfe_pkg::rscfe_axr_s  axr_i,
  input wire rscfe_pkg::rscfe_axo_s  axo_o,
  // serial side and status
  input wire rscfe_pkg::rscfe_byte_s rx_i,
  input wire rscfe_pkg::rscfe_byte_s tx_o,
  input wire rscfe_pkg::rscfe_byte_s fwd_o,
  input wire logic                   event_i,
  input wire logic                   remote_o,
  input wire logic                   unit_open_o,
  input wire logic                   chain_rst_o,
  input wire logic                   cmd_done_o,
  input wire logic                   irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // echo wins over srq, so a control byte always comes back
  chk_ctrl_echo: assert property (
    rx_i.valid && rx_i.data <= 8'h1F |=> tx_o.valid
    && tx_o.data == $past(rx_i.data)) else $error("control not echoed");
  chk_toggle_mode: assert property (
    rx_i.valid && rx_i.data == 8'h01 |=> remote_o != $past(remote_o))
    else $error("toggle byte did not flip mode");
  chk_open_remote: assert property (
    $rose(unit_open_o) |-> remote_o) else $error("opened in local mode");
  chk_open_cause: assert property (
    $rose(unit_open_o) |-> $past(rx_i.valid)) else $error("open without byte");
  chk_lf_done: assert property (
    cmd_done_o |-> $past(rx_i.valid && rx_i.data == 8'h0A && unit_open_o))
    else $error("command done without line feed");
  chk_closed_fwd: assert property (
    rx_i.valid && rx_i.data > 8'h1F && !unit_open_o |=> fwd_o.valid
    && fwd_o.data == $past(rx_i.data)) else $error("byte not passed on");
  chk_chain_cause: assert property (
    chain_rst_o |-> $past(rx_i.valid)) else $error("chain reset unprompted");
  chk_bvalid_hold: assert property (
    axo_o.bvalid && !axw_i.bready |=> axo_o.bvalid) else $error("bvalid lost");
  chk_rvalid_hold: assert property (
    axo_o.rvalid && !axr_i.rready |=> axo_o.rvalid && $stable(axo_o.rdata))
    else $error("read answer lost");
endmodule
bind rscfe_top rscfe_top_props u_rscfe_top_props (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .axw_i(axw_i), .axr_i(axr_i), .axo_o(axo_o),
  .rx_i(rx_i), .tx_o(tx_o), .fwd_o(fwd_o), .event_i(event_i),
  .remote_o(remote_o), .unit_open_o(unit_open_o),
  .chain_rst_o(chain_rst_o), .cmd_done_o(cmd_done_o), .irq_o(irq_o));

// ---- sim/rscfe_host_model.sv ----
// host computer on the serial link: sends bytes, collects replies
`timescale 1ns/1ps
module rscfe_host_model
(
  // plain byte stream, no flow-control lines at all
  input  wire logic                   clk_i,
  output      rscfe_pkg::rscfe_byte_s rx_o,
  input  wire rscfe_pkg::rscfe_byte_s tx_i
);
  logic [7:0] q[$];
  initial rx_o = '{1'b0, 8'h00};
  // everything sent back toward the host
  always @(posedge clk_i)
    if (tx_i.valid === 1'b1)
      q.push_back(tx_i.data);
  // idle data inverted so a stale byte never reads as fresh
  task send(input logic [7:0] b);
    @(posedge clk_i);
    rx_o <= '{1'b1, b};
    @(posedge clk_i);
    rx_o <= '{1'b0, ~b};
  endtask
  // open sequence then the unit address
  task open_unit(input logic [7:0] adr);
    send(8'h03);
    send(8'h02);
    send(adr);
  endtask
  // printable command closed by a line feed
  task command(input logic [7:0] c);
    send(c);
    send(8'h0A);
  endtask
endmodule

// ---- sim/rscfe_top_tb_top.sv ----
// self-checking bench for the serial command front end
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module rscfe_top_tb_top;
  logic clk_i, rst_b_i, ev, remote, uopen, crst, done, irq, ia;
  rscfe_pkg::rscfe_axw_s axw;
  rscfe_pkg::rscfe_axr_s axr;
  rscfe_pkg::rscfe_axo_s axo;
  rscfe_pkg::rscfe_byte_s rx, tx, fwd;
  int fail_count, n_checks, n_done, n_rst;
  logic [7:0] fwd_last;
  logic [31:0] d;
  logic [1:0] r;
  logic [3:0] wstb = 4'hF;
  rscfe_top u_rscfe_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .axw_i(axw),
    .axr_i(axr), .axo_o(axo), .rx_i(rx), .tx_o(tx), .fwd_o(fwd),
    .event_i(ev), .remote_o(remote), .unit_open_o(uopen),
    .chain_rst_o(crst), .cmd_done_o(done), .irq_o(irq));
  rscfe_host_model u_rscfe_host_model (.clk_i(clk_i), .rx_o(rx), .tx_i(tx));
  initial
  begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  // pulse outputs counted so short pulses are not missed
  always @(posedge clk_i)
  begin
    if (done === 1'b1) n_done++;
    if (crst === 1'b1) n_rst++;
    if (fwd.valid === 1'b1) fwd_last <= fwd.data;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    axw <= '{1'b1, a, 1'b1, v, wstb, 1'b1};
    // wait for the answer; only the watchdog ends a hang
    do
    begin
      @(posedge clk_i);
      if (axo.awready) axw.awvalid <= 1'b0;
      if (axo.wready) axw.wvalid <= 1'b0;
    end
    while (axo.bvalid !== 1'b1);
    r = axo.bresp;
    axw.bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    axr <= '{1'b1, a, 1'b1};
    do
    begin
      @(posedge clk_i);
      if (axo.arready) axr.arvalid <= 1'b0;
    end
    while (axo.rvalid !== 1'b1);
    d = axo.rdata;
    r = axo.rresp;
    axr.rready <= 1'b0;
  endtask
  task settle;
    repeat (3) @(posedge clk_i);
  endtask
  task t_reset;
    `CHK("remote", 1'b0, remote)
    rd(rscfe_pkg::A_ADDR);
    `CHK("def_adr", 32'h0000_0041, d)
    rd(8'h20);
    `CHK("unmapped", rscfe_pkg::RESP_SLVERR, r)
    wr(8'h24, 32'h0000_0001);
    `CHK("unmapped_w", rscfe_pkg::RESP_SLVERR, r)
    $display("test reset done");
  endtask
  task t_open;
    u_rscfe_host_model.send(8'h01);
    settle;
    `CHK("echo", 8'h01, u_rscfe_host_model.q[$])
    `CHK("remote", 1'b1, remote)
    wr(rscfe_pkg::A_ADDR, 32'h0000_0042);
    wr(rscfe_pkg::A_CTRL, 32'h0000_0004);
    rd(rscfe_pkg::A_ADDR);
    `CHK("adr", 32'h0000_0042, d)
    u_rscfe_host_model.open_unit(8'h43);
    settle;
    `CHK("other", 1'b0, uopen)
    u_rscfe_host_model.open_unit(8'h42);
    settle;
    `CHK("open", 1'b1, uopen)
    u_rscfe_host_model.command(8'h51);
    settle;
    `CHK("done", 1, n_done)
    u_rscfe_host_model.open_unit(8'h43);
    settle;
    `CHK("closed", 1'b0, uopen)
    u_rscfe_host_model.send(8'h5A);
    settle;
    `CHK("fwd", 8'h5A, fwd_last)
    u_rscfe_host_model.send(8'h03);
    u_rscfe_host_model.send(8'h78);
    settle;
    `CHK("chain_rst", 1, n_rst)
    $display("test open done");
  endtask
  task t_srq;
    wr(rscfe_pkg::A_SRQ, 32'h0000_0053);
    wr(rscfe_pkg::A_CTRL, 32'h0000_0006);
    @(posedge clk_i);
    ev <= 1'b1;
    @(posedge clk_i);
    ev <= 1'b0;
    settle;
    `CHK("srq", 8'h53, u_rscfe_host_model.q[$])
    // low byte lane off: the stored character must not move
    wstb = 4'hE;
    wr(rscfe_pkg::A_SRQ, 32'h0000_0077);
    wstb = 4'hF;
    rd(rscfe_pkg::A_SRQ);
    `CHK("srq_stb", 32'h0000_0053, d)
    rd(rscfe_pkg::A_STATUS);
    `CHK("st_open", 1'b0, d[1])
    wr(rscfe_pkg::A_TXDATA, 32'h0000_000A);
    settle;
    `CHK("reply_lf", 8'h0A, u_rscfe_host_model.q[$])
    $display("test srq done");
  endtask
  task t_irq;
    rd(rscfe_pkg::A_IRQ);
    wr(rscfe_pkg::A_MASK, 32'h0);
    u_rscfe_host_model.send(8'h01);
    settle;
    ia = irq;
    rd(rscfe_pkg::A_IRQ);
    `CHK("irq_tog", 1'b1, d[2])
    rd(rscfe_pkg::A_IRQ);
    `CHK("irq_clr", 1'b0, d[2])
    wr(rscfe_pkg::A_MASK, 32'h0000_001F);
    u_rscfe_host_model.send(8'h01);
    settle;
    `CHK("mask", 1'b1, ia ^ irq)
    rd(rscfe_pkg::A_IRQ);
    settle;
    `CHK("irq_off", 1'b0, irq)
    $display("test irq done");
  endtask
  initial
  begin
    #(100 * 20000);
    fail_count++;
    report_and_stop;
  end
  initial
  begin
    rst_b_i = 0;
    ev = 0;
    axw = '0;
    axr = '0;
    fwd_last = 8'h00;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_reset;
    t_open;
    t_srq;
    t_irq;
    report_and_stop;
  end
endmodule
